// *** include/pfc_prot_pkg.sv ***
package pfc_prot_pkg;

  // ----------------------------------------------------------------
  // clock and time
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 250_000_000;
  localparam longint REDUNDANT_OVERVOLTAGE_EVENT_WINDOW_S = 8;
  localparam longint REDUNDANT_OVERVOLTAGE_EVENT_WINDOW_CYC = REDUNDANT_OVERVOLTAGE_EVENT_WINDOW_S * CLK_HZ;
  localparam int REDUNDANT_OVERVOLTAGE_EVENT_MAX = 10;
  localparam int ADC_W = 12;
  localparam int NREG = 16;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_OLP_THR = 4'h1;
  localparam logic [3:0] R_OC_THR = 4'h2;
  localparam logic [3:0] R_OV_THR = 4'h3;
  localparam logic [3:0] R_REF = 4'h4;
  localparam logic [3:0] R_ROV_RST = 4'h5;
  localparam logic [3:0] R_UV_THR = 4'h6;
  localparam logic [3:0] R_BI_THR = 4'h7;
  localparam logic [3:0] R_BO_THR = 4'h8;
  localparam logic [3:0] R_OV_FILT = 4'h9;
  localparam logic [3:0] R_UV_BLANK = 4'ha;
  localparam logic [3:0] R_BO_BLANK = 4'hb;
  localparam logic [3:0] R_AR_BREAK = 4'hc;
  localparam logic [3:0] R_TON = 4'hd;
  localparam logic [3:0] R_PER_MIN = 4'he;
  localparam logic [3:0] R_PER_MAX = 4'hf;
  localparam logic [5:0] R_STATUS = 6'h10;
  localparam logic [5:0] R_TON_OUT = 6'h11;

  // ctrl bits
  localparam int CTRL_RUN = 0;
  localparam int CTRL_REDUNDANT_OVERVOLTAGE_EVENT_EN = 1;

  // reset values of the writable registers
  localparam logic [31:0] CFG_RST [NREG] = '{
    32'h0000_0000, 32'h0000_0100, 32'h0000_0c00, 32'h0000_0e00,
    32'h0000_0d00, 32'h0000_0d00, 32'h0000_0800, 32'h0000_0600,
    32'h0000_0500, 32'h0000_0010, 32'h0000_1000, 32'h0000_1000,
    32'h0000_1000, 32'h0000_0100, 32'h0000_0200, 32'h0000_1000
  };

  localparam logic [3:0] DCM_SEL = 4'hb;
  localparam logic [3:0] VALLEY_MAX = 4'ha;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_RUN, ST_BOTH_STOP, ST_RESTART
  } sys_e;

endpackage

// *** hw/pfc_multimode_protection_ctrl.sv ***
// How it works
// - first valley: constant on-time, new cycle at first current zero
// - light load: wait for valley two up to ten before next cycle
// - valley choice keeps period within min/max; DCM past tenth valley
// - on-time recomputed every cycle from the selected valley count
// - bus below open-loop level at startup: neither stage starts
// - bus below open-loop level while running: auto-restart
// - shunt above over-current level cuts the gate at once
// - after over-current cut, next cycle on zero-cross or max period
// - averaged bus above over-voltage level stops only the pfc stage
// - fast comparator held for filter time stops only the pfc stage
// - over-voltage stop ends when averaged bus falls to reference
// - redundant input event: count, stop pfc, resume at reset level
// - window restarts per event; late event clears count first
// - redundant count at maximum enters auto-restart
// - redundant protection off after reset, enabled by config bit
// - averaged bus under level for blanking time stops both stages
// - line level above brown-in moves system into startup
// - line level under brown-out for blanking stops only pfc
// - auto-restart stops both, waits break time, then starts again
//
// The register offsets and the APB register port were left to the implementer.
module pfc_multimode_protection_ctrl
  import pfc_prot_pkg::*;
#(
  parameter logic [31:0] REDUNDANT_OVERVOLTAGE_EVENT_WINDOW = 32'(REDUNDANT_OVERVOLTAGE_EVENT_WINDOW_CYC)
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ADC_W-1:0] bus_sense_input,
  input wire logic [ADC_W-1:0] bus_sense_avg,
  input wire logic [ADC_W-1:0] shunt_sense,
  input wire logic zcd_valley,
  input wire logic fast_ov_cmp,
  input wire logic multifunction_sense_input,
  input wire logic [ADC_W-1:0] line_voltage_sense_input,
  output logic pfc_gate,
  output logic llc_enable,
  output logic auto_restart
);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [31:0] cfg_r [NREG];
  logic [31:0] prdata_r;
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire [5:0] widx = paddr[7:2];
  wire mapped = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'b00)
                && (widx <= R_TON_OUT);
  wire cfg_hit = mapped && (widx < 6'(NREG));
  wire wr_en = access_ph & pwrite & cfg_hit;
  wire [31:0] status_w;
  logic [31:0] ton_app_r;
  wire [31:0] rd_mux = cfg_hit ? cfg_r[widx[3:0]]
                     : (widx == R_STATUS) ? status_w
                     : (widx == R_TON_OUT) ? ton_app_r : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (setup_ph)
      prdata_r <= rd_mux;
  end

  generate
    for (genvar i = 0; i < NREG; i++)
    begin : g_cfg
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cfg_r[i] <= CFG_RST[i];
        else if (wr_en && widx[3:0] == 4'(i))
          cfg_r[i] <= pwdata;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  wire run_req = cfg_r[R_CTRL][CTRL_RUN];
  wire redundant_overvoltage_event_en = cfg_r[R_CTRL][CTRL_REDUNDANT_OVERVOLTAGE_EVENT_EN];
  wire [ADC_W-1:0] olp_thr = cfg_r[R_OLP_THR][ADC_W-1:0];
  wire [ADC_W-1:0] oc_thr = cfg_r[R_OC_THR][ADC_W-1:0];
  wire [ADC_W-1:0] ov_thr = cfg_r[R_OV_THR][ADC_W-1:0];
  wire [ADC_W-1:0] ref_lvl = cfg_r[R_REF][ADC_W-1:0];
  wire [ADC_W-1:0] rov_rst = cfg_r[R_ROV_RST][ADC_W-1:0];
  wire [ADC_W-1:0] uv_thr = cfg_r[R_UV_THR][ADC_W-1:0];
  wire [ADC_W-1:0] bi_thr = cfg_r[R_BI_THR][ADC_W-1:0];
  wire [ADC_W-1:0] bo_thr = cfg_r[R_BO_THR][ADC_W-1:0];

  // ----------------------------------------------------------------
  // protection detectors
  // ----------------------------------------------------------------
  logic [31:0] ovf_cnt_r, uv_cnt_r, bo_cnt_r, win_cnt_r;
  logic [3:0] rov_cnt_r;
  logic rov_prev_r, ov_hold_r, rov_hold_r, bo_hold_r;
  sys_e st_r, st_nxt;
  wire running = (st_r == ST_RUN);
  wire open_loop = bus_sense_input < olp_thr;
  wire avg_ov = bus_sense_avg > ov_thr;
  wire fast_ov = fast_ov_cmp && (ovf_cnt_r >= cfg_r[R_OV_FILT]);
  wire rov_evt = redundant_overvoltage_event_en && multifunction_sense_input && !rov_prev_r;
  wire rov_full = rov_cnt_r >= 4'(REDUNDANT_OVERVOLTAGE_EVENT_MAX);
  wire uv_trip = (bus_sense_avg < uv_thr)
                 && (uv_cnt_r >= cfg_r[R_UV_BLANK]);
  wire bo_trip = (line_voltage_sense_input < bo_thr)
                 && (bo_cnt_r >= cfg_r[R_BO_BLANK]);
  wire brownin = line_voltage_sense_input > bi_thr;
  wire pfc_hold = ov_hold_r | rov_hold_r | bo_hold_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovf_cnt_r <= 32'h0000_0000;
    else if (!fast_ov_cmp)
      ovf_cnt_r <= 32'h0000_0000;
    else if (!fast_ov)
      ovf_cnt_r <= ovf_cnt_r + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ov_hold_r <= 1'b0;
    else if (running && (avg_ov || fast_ov))
      ov_hold_r <= 1'b1;
    else if (!running || bus_sense_avg <= ref_lvl)
      ov_hold_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rov_prev_r <= 1'b0;
    else
      rov_prev_r <= multifunction_sense_input;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rov_hold_r <= 1'b0;
    else if (running && rov_evt)
      rov_hold_r <= 1'b1;
    else if (!running || bus_sense_avg <= rov_rst)
      rov_hold_r <= 1'b0;
  end

  // event window and count; a late event restarts the count at one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      win_cnt_r <= 32'h0000_0000;
      rov_cnt_r <= 4'h0;
    end
    else if (running && rov_evt)
    begin
      win_cnt_r <= REDUNDANT_OVERVOLTAGE_EVENT_WINDOW;
      rov_cnt_r <= (win_cnt_r == 32'h0000_0000) ? 4'h1
                   : rov_cnt_r + 4'h1;
    end
    else
    begin
      if (win_cnt_r != 32'h0000_0000)
        win_cnt_r <= win_cnt_r - 32'h0000_0001;
      if (st_r == ST_RESTART)
        rov_cnt_r <= 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      uv_cnt_r <= 32'h0000_0000;
    else if (!running || bus_sense_avg >= uv_thr)
      uv_cnt_r <= 32'h0000_0000;
    else if (!uv_trip)
      uv_cnt_r <= uv_cnt_r + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bo_cnt_r <= 32'h0000_0000;
    else if (!running || line_voltage_sense_input >= bo_thr)
      bo_cnt_r <= 32'h0000_0000;
    else if (!bo_trip)
      bo_cnt_r <= bo_cnt_r + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bo_hold_r <= 1'b0;
    else if (running && bo_trip)
      bo_hold_r <= 1'b1;
    else if (!running || brownin)
      bo_hold_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // system sequencer
  // ----------------------------------------------------------------
  logic [31:0] ar_cnt_r;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:
        if (run_req && brownin)
          st_nxt = ST_START;
      ST_START:
        if (!run_req)
          st_nxt = ST_IDLE;
        else if (!open_loop)
          st_nxt = ST_RUN;
      ST_RUN:
        if (open_loop || rov_full)
          st_nxt = ST_RESTART;
        else if (uv_trip)
          st_nxt = ST_BOTH_STOP;
        else if (!run_req)
          st_nxt = ST_IDLE;
      ST_BOTH_STOP:
        if (!run_req)
          st_nxt = ST_IDLE;
        else if (bus_sense_avg >= uv_thr)
          st_nxt = ST_START;
      ST_RESTART:
        if (ar_cnt_r >= cfg_r[R_AR_BREAK])
          st_nxt = ST_START;
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= ST_IDLE;
    else
      st_r <= st_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ar_cnt_r <= 32'h0000_0000;
    else if (st_r != ST_RESTART)
      ar_cnt_r <= 32'h0000_0000;
    else
      ar_cnt_r <= ar_cnt_r + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // multimode switching engine
  // ----------------------------------------------------------------
  logic on_r, oc_term_r;
  logic [31:0] ton_cnt_r, per_cnt_r;
  logic [3:0] vsel_r, vcnt_r;
  wire pfc_ok = running && !pfc_hold && (st_nxt == ST_RUN);
  wire oc_now = shunt_sense > oc_thr;
  wire per_min_ok = per_cnt_r >= cfg_r[R_PER_MIN];
  wire per_timeout = per_cnt_r >= cfg_r[R_PER_MAX];
  wire [3:0] vcnt_inc = vcnt_r + 4'h1;
  wire valley_hit = zcd_valley && (vcnt_inc >= vsel_r) && per_min_ok;
  wire dcm_go = (vsel_r == DCM_SEL) && per_min_ok;
  wire new_cycle = !on_r && (per_timeout
                   || (oc_term_r ? zcd_valley
                   : (valley_hit || dcm_go)));
  wire ton_done = ton_cnt_r >= ton_app_r;
  wire [31:0] ton_base = cfg_r[R_TON];
  wire [31:0] ton_step = {4'h0, ton_base[31:4]};
  wire [3:0] vsel_nxt;
  wire too_early = !per_min_ok || (vcnt_inc > vsel_r);

  // selected valley came before min period: next valley; timed out:
  // earlier valley; past the tenth valley the engine runs in dcm
  assign vsel_nxt = per_timeout ? ((vsel_r > 4'h1) ? vsel_r - 4'h1 : vsel_r)
                  : (too_early && vsel_r < DCM_SEL) ? vsel_r + 4'h1
                  : vsel_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      on_r <= 1'b0;
      oc_term_r <= 1'b0;
      ton_cnt_r <= 32'h0000_0000;
      per_cnt_r <= 32'h0000_0000;
      vcnt_r <= 4'h0;
    end
    else if (!pfc_ok)
    begin
      on_r <= 1'b0;
      oc_term_r <= 1'b0;
      per_cnt_r <= 32'h0000_0000;
      vcnt_r <= 4'h0;
    end
    else if (on_r)
    begin
      per_cnt_r <= per_cnt_r + 32'h0000_0001;
      ton_cnt_r <= ton_cnt_r + 32'h0000_0001;
      if (oc_now || ton_done)
        on_r <= 1'b0;
      oc_term_r <= oc_now;
    end
    else if (new_cycle || per_cnt_r == 32'h0000_0000)
    begin
      on_r <= 1'b1;
      oc_term_r <= 1'b0;
      ton_cnt_r <= 32'h0000_0001;
      per_cnt_r <= 32'h0000_0001;
      vcnt_r <= 4'h0;
    end
    else
    begin
      per_cnt_r <= per_cnt_r + 32'h0000_0001;
      if (zcd_valley && vcnt_r < VALLEY_MAX)
        vcnt_r <= vcnt_inc;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vsel_r <= 4'h1;
    else if (!pfc_ok)
      vsel_r <= 4'h1;
    else if (new_cycle)
      vsel_r <= vsel_nxt;
  end

  // on-time stretched per extra valley, fixed within a cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ton_app_r <= 32'h0000_0000;
    else if (!on_r)
      ton_app_r <= ton_base
                   + 32'(ton_step * 32'(vsel_r - 4'h1));
  end

  // ----------------------------------------------------------------
  // outputs and status
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      llc_enable <= 1'b0;
      auto_restart <= 1'b0;
    end
    else
    begin
      llc_enable <= (st_nxt == ST_RUN);
      auto_restart <= (st_nxt == ST_RESTART);
    end
  end

  assign pfc_gate = on_r && pfc_ok && !oc_now;

  assign status_w = {16'h0000, rov_cnt_r, vsel_r, 1'b0, st_r,
                     bo_hold_r, rov_hold_r, ov_hold_r, open_loop};

endmodule

// *** verification/pfc_prot_chk_props.sv ***
module pfc_prot_chk
  import pfc_prot_pkg::*;
#(
  parameter logic [31:0] REDUNDANT_OVERVOLTAGE_EVENT_WINDOW = 32'h0000_00c8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADC_W-1:0] bus_sense_input,
  input wire logic [ADC_W-1:0] bus_sense_avg,
  input wire logic [ADC_W-1:0] shunt_sense,
  input wire logic fast_ov_cmp,
  input wire logic [ADC_W-1:0] line_voltage_sense_input,
  input wire logic pfc_gate,
  input wire logic llc_enable,
  input wire logic auto_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // run-length counters, limits assume reset-value thresholds
  // ----------------------------------------------------------------
  logic [15:0] fov_r, bo_r, on_r;
  logic [15:0] fov_nxt, bo_nxt, on_nxt;
  assign fov_nxt = fast_ov_cmp ? fov_r + 16'h0001 : 16'h0000;
  assign bo_nxt = (line_voltage_sense_input < 12'h500) ? bo_r + 16'h0001
                                                        : 16'h0000;
  assign on_nxt = pfc_gate ? on_r + 16'h0001 : 16'h0000;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fov_r <= 16'h0000;
      bo_r <= 16'h0000;
      on_r <= 16'h0000;
    end
    else
    begin
      fov_r <= fov_nxt;
      bo_r <= bo_nxt;
      on_r <= on_nxt;
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_oc_gate_cut:
    assert property (shunt_sense > 12'hc00 |-> !pfc_gate)
    else $error("gate on above overcurrent level");
  a_start_needs_bus:
    assert property ($rose(llc_enable) |-> $past(bus_sense_input) >= 12'h100)
    else $error("half-bridge started with open loop");
  a_open_loop_restart:
    assert property (llc_enable && bus_sense_input < 12'h100
                     |-> ##[1:3] auto_restart)
    else $error("open loop in run without restart");
  a_restart_both_off:
    assert property (auto_restart |-> !pfc_gate && !llc_enable)
    else $error("switching during restart break");
  a_avg_ov_stop:
    assert property ((bus_sense_avg > 12'he00) [*4] |-> !pfc_gate)
    else $error("gate on with averaged overvoltage");
  a_fast_ov_stop:
    assert property (fov_r > 16'h0018 |-> !pfc_gate)
    else $error("gate on after fast overvoltage filter");
  a_brownout_stop:
    assert property (bo_r > 16'h1018 |-> !pfc_gate)
    else $error("gate on after brownout blanking");
  a_ontime_bound:
    assert property (on_r <= 16'h01a1)
    else $error("on-time beyond largest applied value");
  c_restart: cover property ($rose(auto_restart));
  c_oc_cut: cover property ($fell(pfc_gate) && shunt_sense > 12'hc00);
  c_llc_up: cover property ($rose(llc_enable));
endmodule

bind pfc_multimode_protection_ctrl pfc_prot_chk #(
  .REDUNDANT_OVERVOLTAGE_EVENT_WINDOW(REDUNDANT_OVERVOLTAGE_EVENT_WINDOW)
) i_chk (
  .pclk, .presetn, .bus_sense_input, .bus_sense_avg, .shunt_sense,
  .fast_ov_cmp, .line_voltage_sense_input, .pfc_gate, .llc_enable,
  .auto_restart
);

// *** verification/pfc_stage_model.sv ***
module pfc_stage_model
  import pfc_prot_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pfc_gate,
  input wire logic oc_mode,
  output logic [ADC_W-1:0] shunt_sense,
  output logic zcd_valley
);
  timeunit 1ns;
  timeprecision 1ps;
  int off_cnt;
  // ----------------------------------------------------------------
  // current ramps while on; steep ramp forces an overcurrent cut;
  // first valley after 70 cycles of freewheeling, then every 30 cycles
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shunt_sense <= '0;
      zcd_valley <= 1'b0;
      off_cnt <= 0;
    end
    else if (pfc_gate)
    begin
      shunt_sense <= shunt_sense + (oc_mode ? 12'h028 : 12'h006);
      zcd_valley <= 1'b0;
      off_cnt <= 0;
    end
    else
    begin
      shunt_sense <= '0;
      off_cnt <= off_cnt + 1;
      zcd_valley <= off_cnt >= 40 && (off_cnt - 40) % 30 == 29;
    end
  end
endmodule

// *** verification/pfc_multimode_protection_ctrl_bench.sv ***
module pfc_multimode_protection_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pfc_prot_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, q;
  logic zcd_valley, fast_ov_cmp, multifunction_sense_input, oc_mode, gd;
  logic pfc_gate, llc_enable, auto_restart;
  logic [ADC_W-1:0] bus_sense_input, bus_sense_avg, shunt_sense;
  logic [ADC_W-1:0] line_voltage_sense_input;
  int error_cnt, n_compared, cyc, rises, per, t_rise, n0, i;

  pfc_multimode_protection_ctrl #(.REDUNDANT_OVERVOLTAGE_EVENT_WINDOW(32'h0000_00c8)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus_sense_input, .bus_sense_avg, .shunt_sense,
    .zcd_valley, .fast_ov_cmp, .multifunction_sense_input,
    .line_voltage_sense_input, .pfc_gate, .llc_enable, .auto_restart
  );
  pfc_stage_model i_stage (
    .pclk, .presetn, .pfc_gate, .oc_mode, .shunt_sense, .zcd_valley
  );

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // watchdog and gate-start monitor
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    gd <= pfc_gate;
    if (pfc_gate && !gd)
    begin
      rises <= rises + 1;
      per <= cyc - t_rise;
      t_rise <= cyc;
    end
    if (cyc == 60000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never re-drives psel at once
    @(posedge pclk);
  endtask

  task automatic st();
    apb(1'b0, 32'h0000_0040, '0);
  endtask

  task automatic mf_pulse();
    multifunction_sense_input <= 1'b1;
    repeat (4) @(posedge pclk);
    multifunction_sense_input <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  initial
  begin
    {cyc, rises, per, t_rise, error_cnt, n_compared} = '0;
    {presetn, psel, penable, pwrite, gd, oc_mode} = '0;
    {fast_ov_cmp, multifunction_sense_input, paddr, pwdata} = '0;
    bus_sense_input = 12'h080;
    bus_sense_avg = 12'hc00;
    line_voltage_sense_input = 12'h400;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < NREG; i++)
    begin
      apb(1'b0, 32'(4 * i), '0);
      chk(q, CFG_RST[i], "reset value");
    end
    apb(1'b0, 32'h0000_0080, '0);
    chk(er, 1'b1, "unmapped");
    $display("end registers");
    apb(1'b1, 32'h0000_0000, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    st();
    chk(q[6:4], 3'h0, "idle below brown-in");
    line_voltage_sense_input <= 12'h700;
    repeat (20) @(posedge pclk);
    st();
    chk(q[6:4], 3'h1, "startup");
    chk({llc_enable, rises[0]}, 2'h0, "open loop start");
    bus_sense_input <= 12'h800;
    for (i = 0; i < 50 && llc_enable !== 1'b1; i++) @(posedge pclk);
    chk(llc_enable, 1'b1, "llc up");
    for (i = 0; i < 9000 && rises < 12; i++) @(posedge pclk);
    chk(per >= 32'h200 && per <= 32'h1004, 1'b1, "period");
    st();
    n0 = int'(q[11:8]);
    chk(n0 >= 2 && n0 <= 11, 1'b1, "valley");
    apb(1'b0, 32'h0000_0044, '0);
    chk(q, 32'h0000_0100 + 32'h0000_0010 * (n0 - 1), "on-time");
    $display("end switching");
    oc_mode <= 1'b1;
    n0 = rises;
    for (i = 0; i < 9000 && rises < n0 + 4; i++) @(posedge pclk);
    chk(rises >= n0 + 4, 1'b1, "restart after cut");
    oc_mode <= 1'b0;
    bus_sense_avg <= 12'hf00;
    repeat (10) @(posedge pclk);
    st();
    chk(q[1], 1'b1, "ov hold");
    n0 = rises;
    repeat (300) @(posedge pclk);
    chk({llc_enable, rises == n0}, 2'h3, "pfc only stop");
    bus_sense_avg <= 12'hd00;
    for (i = 0; i < 5000 && rises == n0; i++) @(posedge pclk);
    chk(rises > n0, 1'b1, "resume at reference");
    bus_sense_avg <= 12'hc00;
    fast_ov_cmp <= 1'b1;
    repeat (40) @(posedge pclk);
    st();
    chk({q[1], llc_enable}, 2'h3, "fast ov hold");
    fast_ov_cmp <= 1'b0;
    n0 = rises;
    for (i = 0; i < 5000 && rises == n0; i++) @(posedge pclk);
    chk(rises > n0, 1'b1, "resume after fast ov");
    $display("end overvoltage");
    mf_pulse();
    st();
    chk(q[15:12], 4'h0, "redundant off");
    apb(1'b1, 32'h0000_0000, 32'h0000_0003);
    apb(1'b1, 32'h0000_0030, 32'h0000_0040);
    bus_sense_avg <= 12'he00;
    mf_pulse();
    st();
    chk({q[2], llc_enable}, 2'h3, "redundant hold");
    bus_sense_avg <= 12'hc00;
    mf_pulse();
    st();
    chk(q[15:12], 4'h2, "count in window");
    repeat (250) @(posedge pclk);
    mf_pulse();
    st();
    chk(q[15:12], 4'h1, "count after window");
    repeat (9) mf_pulse();
    chk({auto_restart, llc_enable}, 2'h2, "count limit");
    for (i = 0; i < 200 && auto_restart !== 1'b0; i++) @(posedge pclk);
    chk(i >= 48 && i < 80, 1'b1, "break time");
    for (i = 0; i < 300 && llc_enable !== 1'b1; i++) @(posedge pclk);
    chk(llc_enable, 1'b1, "new startup");
    apb(1'b1, 32'h0000_0000, 32'h0000_0001);
    bus_sense_input <= 12'h080;
    repeat (6) @(posedge pclk);
    chk(auto_restart, 1'b1, "open loop in run");
    bus_sense_input <= 12'h800;
    for (i = 0; i < 300 && llc_enable !== 1'b1; i++) @(posedge pclk);
    $display("end restart");
    apb(1'b1, 32'h0000_0028, 32'h0000_0040);
    bus_sense_avg <= 12'h700;
    repeat (48) @(posedge pclk);
    chk(llc_enable, 1'b1, "within uv blanking");
    for (i = 0; i < 60 && llc_enable !== 1'b0; i++) @(posedge pclk);
    st();
    chk({q[6:4], llc_enable, auto_restart}, 5'h0c, "uv stop");
    bus_sense_avg <= 12'hc00;
    for (i = 0; i < 300 && llc_enable !== 1'b1; i++) @(posedge pclk);
    line_voltage_sense_input <= 12'h400;
    repeat (4000) @(posedge pclk);
    st();
    chk(q[3], 1'b0, "within bo blanking");
    repeat (200) @(posedge pclk);
    st();
    chk({q[3], llc_enable}, 2'h3, "brownout");
    line_voltage_sense_input <= 12'h700;
    n0 = rises;
    for (i = 0; i < 5000 && rises == n0; i++) @(posedge pclk);
    chk(rises > n0, 1'b1, "resume after brown-in");
    $display("end undervoltage and brownout");
    conclude();
  end
endmodule
